// ### rtl/adaptation_data_tx_framer.sv
// Adaptation data framer: send path to the MAC and receive indications.
`timescale 1ns/1ns
module adaptation_data_tx_framer
    import adp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input send_req_type send_req,
    output logic send_ready,
    output send_cnf_type send_cnf,
    output logic route_query,
    output logic [15:0] route_dst,
    input wire logic route_done,
    input wire logic route_found,
    input wire logic [15:0] route_next_hop,
    output logic disc_start,
    input wire logic disc_done,
    output logic sec_start,
    input wire logic sec_done,
    input wire logic sec_fail,
    input wire logic [7:0] sec_code,
    output mac_req_type mac_req,
    input wire logic mac_req_ready,
    input mac_cnf_type mac_cnf,
    input rx_frame_type rx_frame,
    output rx_ind_type rx_ind
);

    typedef struct packed {
        fsm_type fsm;
        logic [31:0] ctrl;
        logic [31:0] addr;
        logic [31:0] cfg;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        send_req_type req;
        logic tried;
        logic [15:0] next_hop;
        logic mesh;
        logic [10:0] offset;
        logic [7:0] bseq;
        logic [15:0] ftag;
        logic [7:0] last_status;
        logic send_ready;
        send_cnf_type cnf;
        logic route_query;
        logic disc_start;
        logic sec_start;
        mac_req_type mac;
        rx_ind_type ind;
    } state_type;

    state_type st;
    state_type next_st;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Byte-lane merge of an APB write into a register.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = wdata[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Confirm carrying a status and the tag it answers.
    function automatic send_cnf_type confirm(input logic [7:0] status,
                                             input logic [7:0] tag);
        send_cnf_type c;
        c.valid = 1'b1;
        c.status = status;
        c.tag = tag;
        return c;
    endfunction

    // One MAC request for the fragment that starts at byte off.
    // Fragment payloads are kept to multiples of eight bytes so the
    // offset field stays exact; the last fragment carries the rest.
    function automatic mac_req_type build(input state_type s,
                                          input logic [10:0] off);
        mac_req_type m;
        logic [10:0] h;
        logic [10:0] chunk;
        logic [10:0] rest;
        m = '0;
        h = 11'h000;
        if (s.mesh) begin
            h = MESH_HDR_LEN;
        end
        if (s.req.multicast) begin
            h = h + BC_HDR_LEN;
        end
        chunk = (MAC_PAYLOAD_MAX - h - FRAGN_LEN) & FRAG_MASK;
        rest = s.req.length - off;
        m.valid = 1'b1;
        m.src_mode = ADDR_MODE_SHORT;
        m.dst_mode = ADDR_MODE_SHORT;
        m.src_pan = s.addr[PAN_LSB +: 16];
        m.dst_pan = s.addr[PAN_LSB +: 16];
        m.src_addr = s.addr[15:0];
        // Multicast goes to everyone, unicast to the chosen next hop.
        m.dst_addr = s.req.multicast ? BCAST_ADDR : s.next_hop;
        m.handle = s.req.tag;
        m.tx_options = TX_OPT_ACK;
        m.sec_level = s.cfg[SECLVL_LSB +: 3];
        if (m.sec_level != SEC_NONE) begin
            m.key_index = s.cfg[KEYIDX_LSB +: 8];
        end
        m.mesh_present = s.mesh;
        m.mesh_byte = {MESH_DISPATCH, 1'b1, 1'b1, s.cfg[HOPS_LSB +: 4]};
        m.originator = s.addr[15:0];
        m.final_dst = s.req.dst;
        m.bc_present = s.req.multicast;
        m.bc_seq = s.bseq;
        m.data_offset = off;
        if (off == 11'h000 && h + s.req.length <= MAC_PAYLOAD_MAX) begin
            m.data_len = s.req.length;
            m.length = h + s.req.length;
        end else begin
            m.frag_present = 1'b1;
            m.frag_first = (off == 11'h000);
            m.frag_size = s.req.length;
            m.frag_tag = s.ftag;
            m.frag_offset = off[10:3];
            m.data_len = (rest < chunk) ? rest : chunk;
            m.length = h + (m.frag_first ? FRAG1_LEN : FRAGN_LEN)
                       + m.data_len;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // APB slave, receive filter and send sequencer in one pass.
    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.route_query = 1'b0;
        next_st.disc_start = 1'b0;
        next_st.sec_start = 1'b0;
        next_st.cnf.valid = 1'b0;
        next_st.ind.valid = 1'b0;

        // Read data is prepared in the setup cycle so pready can come
        // from a flop; this costs exactly one wait-free access cycle.
        if (psel && !penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h00000000;
            case (paddr)
                CTRL_OFFSET: next_st.prdata = st.ctrl;
                ADDR_OFFSET: next_st.prdata = st.addr;
                CFG_OFFSET: next_st.prdata = st.cfg;
                STAT_OFFSET: next_st.prdata = {st.last_status, st.bseq,
                                               9'h000, st.fsm};
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && pwrite && st.pready && !st.pslverr) begin
            case (paddr)
                CTRL_OFFSET: next_st.ctrl = merge(st.ctrl, pwdata, pstrb);
                ADDR_OFFSET: next_st.addr = merge(st.addr, pwdata, pstrb);
                CFG_OFFSET: next_st.cfg = merge(st.cfg, pwdata, pstrb);
                default: next_st.ctrl = st.ctrl;
            endcase
        end

        // Only frames whose final destination is this station or the broadcast address go up.
        if (rx_frame.valid && rx_frame.length <= MAX_NSDU &&
            (rx_frame.final_dst == st.addr[15:0] ||
             rx_frame.final_dst == BCAST_ADDR)) begin
            next_st.ind.valid = 1'b1;
            next_st.ind.length = rx_frame.length;
            next_st.ind.lqi = rx_frame.lqi;
        end

        case (st.fsm)
            IDLE: begin
                if (st.send_ready && send_req.valid) begin
                    next_st.req = send_req;
                    next_st.offset = 11'h000;
                    next_st.tried = 1'b0;
                    if (!st.ctrl[JOINED_BIT]) begin
                        next_st.cnf = confirm(ST_INVALID_REQUEST,
                                              send_req.tag);
                        next_st.last_status = ST_INVALID_REQUEST;
                        next_st.fsm = CONFIRM;
                    end else if (send_req.multicast) begin
                        next_st.mesh = 1'b1;
                        next_st.bseq = st.bseq + 8'h01;
                        next_st.sec_start = 1'b1;
                        next_st.fsm = SECURE;
                    end else if (st.ctrl[NO_ROUTE_BIT]) begin
                        next_st.mesh = 1'b0;
                        next_st.next_hop = send_req.dst;
                        next_st.sec_start = 1'b1;
                        next_st.fsm = SECURE;
                    end else begin
                        next_st.route_query = 1'b1;
                        next_st.fsm = ROUTE;
                    end
                end
            end
            ROUTE: begin
                if (route_done) begin
                    if (route_found) begin
                        next_st.next_hop = route_next_hop;
                        next_st.mesh = !st.req.neighbour;
                        next_st.sec_start = 1'b1;
                        next_st.fsm = SECURE;
                    end else if (st.req.discover && !st.tried) begin
                        next_st.tried = 1'b1;
                        next_st.disc_start = 1'b1;
                        next_st.fsm = DISC;
                    end else begin
                        next_st.cnf = confirm(ST_ROUTE_ERROR, st.req.tag);
                        next_st.last_status = ST_ROUTE_ERROR;
                        next_st.fsm = CONFIRM;
                    end
                end
            end
            DISC: begin
                // One discovery per request, then the table is asked again.
                if (disc_done) begin
                    next_st.route_query = 1'b1;
                    next_st.fsm = ROUTE;
                end
            end
            SECURE: begin
                if (sec_done) begin
                    if (sec_fail) begin
                        next_st.cnf = confirm(sec_code, st.req.tag);
                        next_st.last_status = sec_code;
                        next_st.fsm = CONFIRM;
                    end else begin
                        next_st.mac = build(st, 11'h000);
                        next_st.fsm = MAC;
                    end
                end
            end
            MAC: begin
                if (mac_req_ready) begin
                    next_st.mac.valid = 1'b0;
                    next_st.fsm = WAIT;
                end
            end
            WAIT: begin
                if (mac_cnf.valid) begin
                    next_st.offset = st.offset + st.mac.data_len;
                    if (mac_cnf.status == ST_SUCCESS &&
                        next_st.offset < st.req.length) begin
                        next_st.mac = build(st, next_st.offset);
                        next_st.fsm = MAC;
                    end else begin
                        // A MAC status is passed up unchanged.
                        next_st.cnf = confirm(mac_cnf.status,
                                              st.req.tag);
                        next_st.last_status = mac_cnf.status;
                        if (st.mac.frag_present) begin
                            next_st.ftag = st.ftag + 16'h0001;
                        end
                        next_st.fsm = CONFIRM;
                    end
                end
            end
            CONFIRM: begin
                next_st.fsm = IDLE;
            end
            default: begin
                next_st.fsm = IDLE;
            end
        endcase

        // Requests are taken one at a time, so a tag is never shadowed.
        next_st.send_ready = (next_st.fsm == IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    // The clock enable freezes every flop, bus answers included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.fsm <= IDLE;
            st.ctrl <= CTRL_RESET;
            st.addr <= ADDR_RESET;
            st.cfg <= CFG_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Every output is a field of the state flop.
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign send_ready = st.send_ready;
    assign send_cnf = st.cnf;
    assign route_query = st.route_query;
    assign route_dst = st.req.dst;
    assign disc_start = st.disc_start;
    assign sec_start = st.sec_start;
    assign mac_req = st.mac;
    assign rx_ind = st.ind;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence take_s;
        ce && st.send_ready && send_req.valid;
    endsequence

    sequence sec_fail_s;
        ce && st.fsm == SECURE && sec_done && sec_fail;
    endsequence

    reject_cnf_a: assert property (
        take_s and !st.ctrl[JOINED_BIT] |=> send_cnf.valid &&
        send_cnf.status == ST_INVALID_REQUEST && !mac_req.valid ##1
        !mac_req.valid)
        else $error("unjoined request not rejected");

    mesh_hdr_a: assert property (
        mac_req.valid && mac_req.mesh_present |->
        mac_req.mesh_byte == {2'h2, 2'h3, st.cfg[3:0]} &&
        mac_req.originator == st.addr[15:0])
        else $error("mesh header fields wrong");

    mac_fields_a: assert property (
        mac_req.valid |-> mac_req.src_mode == 2'h2 &&
        mac_req.dst_mode == 2'h2 && mac_req.src_pan == st.addr[31:16] &&
        mac_req.dst_pan == st.addr[31:16] &&
        mac_req.src_addr == st.addr[15:0] &&
        mac_req.tx_options[0] && mac_req.handle == st.req.tag)
        else $error("MAC request fields wrong");

    bcast_dst_a: assert property (
        mac_req.valid && st.req.multicast |-> mac_req.dst_addr == BCAST_ADDR &&
        mac_req.bc_present && mac_req.mesh_present)
        else $error("multicast frame fields wrong");

    seq_step_a: assert property (
        take_s and st.ctrl[JOINED_BIT] && send_req.multicast |=>
        st.bseq == $past(st.bseq) + 8'h01)
        else $error("broadcast sequence not stepped");

    frag_fit_a: assert property (
        mac_req.valid |-> mac_req.length <= MAC_PAYLOAD_MAX &&
        (mac_req.frag_present || mac_req.data_len == st.req.length))
        else $error("frame exceeds MAC payload");

    bypass_a: assert property (
        mac_req.valid && st.ctrl[NO_ROUTE_BIT] && !st.req.multicast |->
        !mac_req.mesh_present && mac_req.dst_addr == st.req.dst)
        else $error("routing bypass not honoured");

    sec_drop_a: assert property (
        sec_fail_s |=> send_cnf.valid &&
        send_cnf.status == $past(sec_code) && !mac_req.valid)
        else $error("security failure not confirmed");

    rx_ind_a: assert property (
        rx_frame.valid && ce && rx_frame.length <= MAX_NSDU &&
        rx_frame.final_dst == st.addr[15:0] |=> rx_ind.valid &&
        rx_ind.lqi == $past(rx_frame.lqi))
        else $error("received frame not indicated");

    one_cnf_a: assert property (
        send_cnf.valid |-> st.fsm == CONFIRM && !send_ready &&
        send_cnf.tag == st.req.tag)
        else $error("stray confirm");

endmodule

// ### common/adp_pkg.sv
// Shared constants and carrier types of the adaptation data framer.
package adp_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] ADDR_OFFSET = 12'h004;
    localparam logic [11:0] CFG_OFFSET = 12'h008;
    localparam logic [11:0] STAT_OFFSET = 12'h00C;
    // Field positions.
    localparam int JOINED_BIT = 0;
    localparam int NO_ROUTE_BIT = 1;
    localparam int PAN_LSB = 16;
    localparam int HOPS_LSB = 0;
    localparam int SECLVL_LSB = 8;
    localparam int KEYIDX_LSB = 16;
    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] ADDR_RESET = 32'h0000FFFF;
    localparam logic [31:0] CFG_RESET = 32'h00000008;
    // Frame field values.
    localparam logic [1:0] ADDR_MODE_SHORT = 2'h2;
    localparam logic [1:0] MESH_DISPATCH = 2'h2;
    localparam logic [15:0] BCAST_ADDR = 16'hFFFF;
    localparam logic [7:0] TX_OPT_ACK = 8'h01;
    localparam logic [2:0] SEC_NONE = 3'h0;
    localparam logic [10:0] MESH_HDR_LEN = 11'h005;
    localparam logic [10:0] BC_HDR_LEN = 11'h002;
    localparam logic [10:0] FRAG1_LEN = 11'h004;
    localparam logic [10:0] FRAGN_LEN = 11'h005;
    localparam logic [10:0] FRAG_MASK = 11'h7F8;
    localparam logic [10:0] MAC_PAYLOAD_MAX = 11'h05A;
    localparam logic [10:0] MAX_NSDU = 11'h500;
    // Confirm status codes.
    localparam logic [7:0] ST_SUCCESS = 8'h00;
    localparam logic [7:0] ST_INVALID_REQUEST = 8'hA1;
    localparam logic [7:0] ST_ROUTE_ERROR = 8'hA2;
    // Quality of service encodings.
    localparam logic QOS_NORMAL = 1'b0;
    localparam logic QOS_HIGH = 1'b1;

    typedef enum logic [6:0] {
        IDLE = 7'h01,
        ROUTE = 7'h02,
        DISC = 7'h04,
        SECURE = 7'h08,
        MAC = 7'h10,
        WAIT = 7'h20,
        CONFIRM = 7'h40
    } fsm_type;

    typedef struct packed {
        logic valid;
        logic [10:0] length;
        logic [7:0] tag;
        logic discover;
        logic qos;
        logic multicast;
        logic neighbour;
        logic [15:0] dst;
    } send_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] status;
        logic [7:0] tag;
    } send_cnf_type;

    typedef struct packed {
        logic valid;
        logic [1:0] src_mode;
        logic [1:0] dst_mode;
        logic [15:0] src_pan;
        logic [15:0] dst_pan;
        logic [15:0] src_addr;
        logic [15:0] dst_addr;
        logic [10:0] length;
        logic [7:0] handle;
        logic [7:0] tx_options;
        logic [2:0] sec_level;
        logic [7:0] key_index;
        logic mesh_present;
        logic [7:0] mesh_byte;
        logic [15:0] originator;
        logic [15:0] final_dst;
        logic bc_present;
        logic [7:0] bc_seq;
        logic frag_present;
        logic frag_first;
        logic [10:0] frag_size;
        logic [15:0] frag_tag;
        logic [7:0] frag_offset;
        logic [10:0] data_offset;
        logic [10:0] data_len;
    } mac_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] status;
    } mac_cnf_type;

    typedef struct packed {
        logic valid;
        logic [15:0] final_dst;
        logic [10:0] length;
        logic [7:0] lqi;
    } rx_frame_type;

    typedef struct packed {
        logic valid;
        logic [10:0] length;
        logic [7:0] lqi;
    } rx_ind_type;
endpackage

// ### verification/mac_model.sv
// Model of the MAC data service facing the framer.
`timescale 1ns/1ns
module mac_model
    import adp_pkg::*;
(
    input wire logic pclk,
    input mac_req_type mac_req,
    output logic mac_req_ready,
    output mac_cnf_type mac_cnf
);
    // Nothing is offered before the first edge.
    initial begin
        mac_req_ready = 1'b0;
        mac_cnf = '0;
    end
    // Ready comes at random, so the framer must hold each request.
    // A taken request is confirmed one cycle later.
    always @(posedge pclk) begin
        mac_cnf.valid <= mac_req.valid && mac_req_ready;
        mac_cnf.status <= ST_SUCCESS;
        mac_req_ready <= mac_req.valid && ($urandom % 3 == 0);
    end
endmodule

// ### verification/test_adaptation_data_tx_framer.sv
// Self-checking bench of the adaptation data framer.
`timescale 1ns/1ns
module test_adaptation_data_tx_framer;
    import adp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0;
    logic penable = 1'b0, pwrite = 1'b0, err, byp = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, send_ready, route_query, disc_start, sec_start;
    logic route_done = 1'b0, route_found = 1'b1, disc_done = 1'b0;
    logic sec_done = 1'b0, sec_fail = 1'b0, mac_req_ready;
    logic e_mesh, e_bc, e_frag, e_route;
    logic [7:0] sec_code = 8'h5C, e_tag;
    logic [15:0] route_dst, e_dst, e_fin, route_next_hop = 16'h0123;
    logic [15:0] own = 16'h1234, pan = 16'h0ACE;
    logic [3:0] hops = 4'h6;
    logic [11:0] e_opt = 12'h800;
    logic [10:0] e_len;
    logic [11:0] ra [3] = '{CTRL_OFFSET, ADDR_OFFSET, CFG_OFFSET};
    logic [31:0] rv [3] = '{CTRL_RESET, ADDR_RESET, CFG_RESET};
    send_req_type send_req = '0;
    send_cnf_type send_cnf;
    mac_req_type mr;
    mac_cnf_type mac_cnf;
    rx_frame_type rx_frame = '0;
    rx_ind_type rx_ind;
    int n_fail = 0, checks = 0, cyc = 0, sum, nmac, ncnf = 0, nsent = 0;
    int ndisc = 0, seq = -1, last = -1;

    adaptation_data_tx_framer dut (.pclk, .presetn, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .send_req, .send_ready, .send_cnf, .route_query, .route_dst,
        .route_done, .route_found, .route_next_hop, .disc_start, .disc_done,
        .sec_start, .sec_done, .sec_fail, .sec_code, .mac_req(mr),
        .mac_req_ready, .mac_cnf, .rx_frame, .rx_ind);
    mac_model u_mac (.pclk, .mac_req(mr), .mac_req_ready, .mac_cnf);
////////////////////////////////////////
    always #2 pclk = ~pclk;

    // Compare, count and report; four-state so an unknown never matches.
    function automatic void chk(string n, logic [63:0] e, logic [63:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endfunction

    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Routing, discovery and security answer one cycle after each start.
    always @(posedge pclk) begin
        route_done <= route_query;
        disc_done <= disc_start;
        sec_done <= sec_start;
        ndisc += disc_start;
        ncnf += send_cnf.valid;
        cyc++;
        if (route_query === 1'b1) begin
            chk("route", {e_route, e_fin}, {1'b1, route_dst});
        end
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    // Each request the MAC takes is held against the model's figures.
    always @(posedge pclk) begin
        if (mr.valid === 1'b1 && mac_req_ready === 1'b1) begin
            nmac++;
            chk("offset", sum, mr.data_offset);
            if (e_frag) begin
                chk("frag", {sum[10:3], sum == 0}, {mr.frag_offset,
                    mr.frag_first});
            end
            sum += mr.data_len;
            chk("modes", {4'hA, pan, pan, own}, {mr.src_mode, mr.dst_mode,
                mr.src_pan, mr.dst_pan, mr.src_addr});
            chk("dst", e_dst, mr.dst_addr);
            chk("opts", {e_tag, e_opt}, {mr.handle, mr.tx_options[0],
                mr.sec_level, mr.key_index});
            chk("hdrs", {e_mesh, e_bc, e_frag}, {mr.mesh_present,
                mr.bc_present, mr.frag_present});
            if (e_mesh) begin
                chk("mesh", {4'hB, hops, own, e_fin}, {mr.mesh_byte,
                    mr.originator, mr.final_dst});
            end
            if (!e_frag) begin
                chk("len", e_len, mr.length);
            end
            chk("fit", 1, mr.length <= MAC_PAYLOAD_MAX);
            if (e_bc && seq >= 0) begin
                chk("seq", seq, mr.bc_seq);
            end
            if (e_bc) begin
                seq = mr.bc_seq;
                last = mr.bc_seq;
            end
        end
    end

    // One APB transfer; the leading edge keeps back-to-back calls apart.
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One send request, confirmed and counted against the model.
    task automatic send(string nm, logic [10:0] len, logic mc, nb, dsc,
            logic [7:0] st);
        int t;
        e_tag = 8'($urandom);
        e_mesh = mc | (!nb & !byp);
        e_bc = mc;
        e_route = !mc & !byp;
        e_fin = mc ? 16'h8001 : 16'h0456;
        e_dst = mc ? BCAST_ADDR : (byp ? e_fin : route_next_hop);
        e_len = len + (e_mesh ? MESH_HDR_LEN : 0) + (e_bc ? BC_HDR_LEN : 0);
        // A frame that would overrun one MAC payload must be cut.
        e_frag = e_len > MAC_PAYLOAD_MAX;
        seq = (mc && last >= 0) ? (last + 1) % 256 : -1;
        sum = 0;
        nmac = 0;
        while (send_ready !== 1'b1) @(posedge pclk);
        send_req <= {1'b1, len, e_tag, dsc, 1'($urandom), mc, nb, e_fin};
        @(posedge pclk);
        send_req.valid <= 1'b0;
        for (t = 0; t < 500 && send_cnf.valid !== 1'b1; t++) @(posedge pclk);
        chk("cnf", {1'b1, st, e_tag}, {send_cnf.valid, send_cnf.status,
            send_cnf.tag});
        chk("sent", {st == 8'h00, st == 8'h00 ? len : 11'h000},
            {nmac > 0, sum[10:0]});
        repeat (3) @(posedge pclk);
        nsent++;
        chk("count", nsent, ncnf);
        $display("test %s done", nm);
    endtask

    // One received frame; the indication is due one cycle after it.
    task automatic rx(logic [15:0] d, logic [10:0] len, logic hit);
        logic [7:0] lq;
        lq = 8'($urandom);
        rx_frame <= {1'b1, d, len, lq};
        @(posedge pclk);
        rx_frame.valid <= 1'b0;
        @(posedge pclk);
        chk("ind", hit, rx_ind.valid);
        if (hit) begin
            chk("ind data", {len, lq}, {rx_ind.length, rx_ind.lqi});
        end
        $display("test rx done");
    endtask

    // Main sequence.
    initial begin
        void'($urandom(66));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h00000000);
            chk("reset", {1'b0, rv[i]}, {err, rd});
        end
        apb(1'b0, 12'h010, 32'h00000000);
        chk("unmapped", 1'b1, err);
        apb(1'b1, ADDR_OFFSET, {pan, own});
        apb(1'b1, CFG_OFFSET, {28'h0000000, hops});
        apb(1'b0, ADDR_OFFSET, 32'h00000000);
        chk("addr", {pan, own}, rd);
        $display("test registers done");
        send("unjoined", 11'd20, 1'b0, 1'b0, 1'b0, 8'hA1);
        apb(1'b1, CTRL_OFFSET, 32'h00000001);
        send("mesh", 11'd20, 1'b0, 1'b0, 1'b1, 8'h00);
        send("neighbour", 11'd60, 1'b0, 1'b1, 1'b0, 8'h00);
        send("group", 11'd0, 1'b1, 1'b0, 1'b0, 8'h00);
        send("group frag", 11'd300, 1'b1, 1'b0, 1'b0, 8'h00);
        send("frag", 11'd1280, 1'b0, 1'b0, 1'b0, 8'h00);
        route_found <= 1'b0;
        send("no route", 11'd20, 1'b0, 1'b0, 1'b1, 8'hA2);
        chk("discover", 1, ndisc);
        route_found <= 1'b1;
        sec_fail <= 1'b1;
        send("sec fail", 11'd20, 1'b0, 1'b0, 1'b0, sec_code);
        sec_fail <= 1'b0;
        apb(1'b1, CTRL_OFFSET, 32'h00000003);
        apb(1'b1, CFG_OFFSET, {8'h00, 8'h5A, 5'h00, 3'h3, 4'h0, hops});
        e_opt = 12'hB5A;
        byp = 1'b1;
        send("bypass", 11'd20, 1'b0, 1'b0, 1'b0, 8'h00);
        rx(own, 11'd40, 1'b1);
        rx(16'hFFFF, 11'd1280, 1'b1);
        rx(own, 11'd1281, 1'b0);
        rx(16'h0777, 11'd40, 1'b0);
        // A low clock enable must freeze the receive filter too.
        ce <= 1'b0;
        rx(own, 11'd40, 1'b0);
        ce <= 1'b1;
        apb(1'b0, STAT_OFFSET, 32'h00000000);
        chk("stat", {8'h00, 8'(last), 9'h000, IDLE}, rd);
        $display("test status done");
        test_done();
    end
endmodule
